// ---- hdl/emb_pkg.sv ----
// Constants and types shared by the external memory bus port logic
// Overview of operation
// - Low port general output is open drain
// - Low port multiplexes address and data, strongly
// - Other ports quasi-bidirectional with weak pullup
// - Upper port drives high address byte
// - Register-indirect moves keep upper latch contents
// - Reset held two machine cycles; pulldown
// - Reset forces all port pins immediately
// - Address latch strobe captures low address
// - Strobe steady rate, one skipped per move
// - Fetch strobe twice per cycle, two skipped; here at most once, no two fetch slots in a row
// - Strap low means all code external
// - Locked part holds strap sampled at reset
// - Strobe port bit 6 writes, bit 7 reads
// - 16K internal code, 64K external spaces
// - Aux bit suppresses strobe on fetches
package emb_pkg;
    // Timing: one bus slot is half a machine cycle
    localparam int unsigned OSC_CLKS_PER_MACHINE = 12;
    localparam int unsigned SLOT_CLKS = OSC_CLKS_PER_MACHINE / 2;
    localparam int unsigned RESET_HOLD_CLKS = 2 * OSC_CLKS_PER_MACHINE;
    localparam logic [2:0] PH_LAST = 3'h5;
    localparam logic [2:0] PH_ADDR_END = 3'h2;
    localparam logic [2:0] PH_FETCH_START = 3'h3;
    localparam logic [2:0] PH_STRB_START = 3'h1;
    localparam logic [2:0] PH_STRB_END = 3'h4;
    localparam logic [2:0] PH_SAMPLE = 3'h4;

    // Memory sizes
    localparam int unsigned INT_CODE_BYTES = 16384;
    localparam int unsigned EXT_CODE_BYTES = 65536;
    localparam int unsigned EXT_DATA_BYTES = 65536;
    localparam int unsigned INT_RAM_BYTES = 256;
    localparam logic [15:0] INT_CODE_LIMIT = 16'h4000;

    // Pin values after reset
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic STRAP_RESET = 1'h1;

    // Strobe positions on the strobe port
    localparam int unsigned WR_BIT = 6;
    localparam int unsigned RD_BIT = 7;

    // Bus slot kinds, Gray along idle -> fetch -> address -> strobe
    typedef enum logic [1:0]
    {
        SL_IDLE = 2'h0,
        SL_FETCH = 2'h1,
        SL_DADDR = 2'h3,
        SL_DSTRB = 2'h2
    } emb_slot_t;
endpackage

// ---- hdl/emb_quasi_drv.sv ----
// Quasi-bidirectional port driver with strong override
module emb_quasi_drv
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn_int,
    // Latch and override
    input wire logic [7:0] latch,
    input wire logic [7:0] ovr_en,
    input wire logic [7:0] ovr_val,
    // Pin drive
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    import emb_pkg::*;

    // Weak pullup is left to the board; a one releases the pin
    wire [7:0] next_oe = ovr_en | ~latch;
    wire [7:0] next_out = ovr_en & ovr_val;

    // Released at once by reset, clock or not
    always_ff @(posedge core_clk or negedge rstn_int)
    begin
        if (!rstn_int)
        begin
            pin_oe <= ~PORT_RESET;
            pin_out <= 8'h00;
        end
        else
        begin
            pin_oe <= next_oe;
            pin_out <= next_out;
        end
    end
endmodule

// ---- hdl/emb_bus_ports.sv ----
// External memory bus sequencer and port pin drivers
module emb_bus_ports
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Port latches from the core
    input wire logic [7:0] low_port_latch,
    input wire logic [7:0] upper_port_latch,
    input wire logic [7:0] gp_port_latch,
    input wire logic [7:0] strobe_port_latch,
    // Configuration
    input wire logic external_access_strap,
    input wire logic lock_programmed,
    input wire logic ale_suppress,
    // Code fetch request
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic fetch_external,
    output logic fetch_ack,
    output logic [7:0] fetch_data,
    // Data move request
    input wire logic data_req,
    input wire logic data_write,
    input wire logic data_pointer,
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_wdata,
    output logic data_ack,
    output logic [7:0] data_rdata,
    // Low port pins
    input wire logic [7:0] low_port_in,
    output logic [7:0] low_port_out,
    output logic [7:0] low_port_oe,
    // Upper, general and strobe port pins
    output logic [7:0] upper_port_out,
    output logic [7:0] upper_port_oe,
    output logic [7:0] gp_port_out,
    output logic [7:0] gp_port_oe,
    output logic [7:0] strobe_port_out,
    output logic [7:0] strobe_port_oe,
    // Bus strobes
    output logic address_latch_strobe,
    output logic program_fetch_strobe_n
);
    import emb_pkg::*;

    logic rst_q1;
    logic rstn_int;
    logic strap_hold;
    logic strap_taken;
    emb_slot_t slot;
    logic [2:0] ph;
    logic [15:0] cur_addr;
    logic [7:0] cur_wdata;
    logic cur_write;
    logic cur_ptr;
    emb_slot_t next_slot;
    logic ale_sup_q;
    logic [1:0] chk_live;

    // Reset assert is immediate, release is synchronised
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_q1 <= 1'h0;
            rstn_int <= 1'h0;
        end
        else
        begin
            rst_q1 <= 1'h1;
            rstn_int <= rst_q1;
        end
    end

    // Strap caught once after release; only used on locked parts
    always_ff @(posedge core_clk or negedge rstn_int)
    begin
        if (!rstn_int)
        begin
            strap_hold <= STRAP_RESET;
            strap_taken <= 1'h0;
        end
        else if (!strap_taken)
        begin
            strap_hold <= external_access_strap;
            strap_taken <= 1'h1;
        end
    end

    // Effective strap and external code decision
    wire strap_eff = lock_programmed ? strap_hold : external_access_strap;
    wire beyond_int = fetch_addr >= INT_CODE_LIMIT;
    assign fetch_external = !strap_eff || beyond_int;

    // Slot decode
    wire is_fetch = slot == SL_FETCH;
    wire is_daddr = slot == SL_DADDR;
    wire is_dstrb = slot == SL_DSTRB;
    wire is_data = is_daddr || is_dstrb;
    wire ph_last = ph == PH_LAST;

    // Combinational handshake; data registers are valid from phase 5
    assign fetch_ack = is_fetch && ph_last;
    assign data_ack = is_dstrb && ph_last;

    // Slot scheduling: a data move steals two slots from fetches
    always_comb
    begin
        next_slot = SL_IDLE;
        if (is_daddr)
            next_slot = SL_DSTRB;
        else if (data_req && !data_ack)
            next_slot = SL_DADDR;
        else if (fetch_req && !fetch_ack && fetch_external)
            next_slot = SL_FETCH;
    end

    // Phase counter, slot register, strobe suppression and check warm-up
    always_ff @(posedge core_clk or negedge rstn_int)
    begin
        if (!rstn_int)
        begin
            ph <= 3'h0;
            slot <= SL_IDLE;
            ale_sup_q <= 1'h0;
            chk_live <= 2'h0;
        end
        else
        begin
            ph <= ph_last ? 3'h0 : ph + 3'h1;
            slot <= ph_last ? next_slot : slot;
            // Taken at slot edges only, so a toggle never leaves a runt strobe
            ale_sup_q <= ph_last ? ale_suppress : ale_sup_q;
            chk_live <= {chk_live[0], 1'h1};
        end
    end

    // Request capture at the slot boundary
    always_ff @(posedge core_clk or negedge rstn_int)
    begin
        if (!rstn_int)
        begin
            cur_addr <= 16'h0000;
            cur_wdata <= 8'h00;
            cur_write <= 1'h0;
            cur_ptr <= 1'h0;
        end
        else if (ph_last && next_slot == SL_DADDR)
        begin
            cur_addr <= data_addr;
            cur_wdata <= data_wdata;
            cur_write <= data_write;
            cur_ptr <= data_pointer;
        end
        else if (ph_last && next_slot == SL_FETCH)
        begin
            cur_addr <= fetch_addr;
        end
    end

    // Returned bytes sampled a cycle before the acknowledge
    always_ff @(posedge core_clk or negedge rstn_int)
    begin
        if (!rstn_int)
        begin
            fetch_data <= 8'h00;
            data_rdata <= 8'h00;
        end
        else
        begin
            if (is_fetch && ph == PH_SAMPLE)
                fetch_data <= low_port_in;
            if (is_dstrb && !cur_write && ph == PH_SAMPLE)
                data_rdata <= low_port_in;
        end
    end

    // Strobe timing inside a slot
    wire addr_ph = ph < PH_ADDR_END;
    wire strb_ph = ph >= PH_STRB_START && ph <= PH_STRB_END;
    // Idle slots stand for internal fetches, so suppression covers them
    wire ale_c = addr_ph && !is_dstrb && !(ale_sup_q && !is_daddr);
    wire program_fetch_strobe_c = is_fetch && ph >= PH_FETCH_START;

    // Low port: bus multiplex in bus slots, open drain otherwise
    wire bus_mode = slot != SL_IDLE;
    wire drv_addr = (is_fetch || is_daddr) && addr_ph;
    wire drv_wdata = is_data && cur_write && !addr_ph;
    wire [7:0] bus_val = drv_addr ? cur_addr[7:0] : cur_wdata;
    wire [7:0] next_low_oe = bus_mode ? {8{drv_addr || drv_wdata}} : ~low_port_latch;
    wire [7:0] next_low_out = bus_mode ? bus_val : 8'h00;

    // Low port and bus strobe registers
    always_ff @(posedge core_clk or negedge rstn_int)
    begin
        if (!rstn_int)
        begin
            low_port_oe <= ~PORT_RESET;
            low_port_out <= 8'h00;
            address_latch_strobe <= 1'h0;
            program_fetch_strobe_n <= 1'h1;
        end
        else
        begin
            low_port_oe <= next_low_oe;
            low_port_out <= next_low_out;
            address_latch_strobe <= ale_c;
            program_fetch_strobe_n <= !program_fetch_strobe_c;
        end
    end

    // Override sets for the three quasi ports
    wire hi_drv = is_fetch || (is_data && cur_ptr);
    wire wr_c = is_dstrb && cur_write && strb_ph;
    wire rd_c = is_dstrb && !cur_write && strb_ph;
    wire [7:0] strb_en = {rd_c, wr_c, 6'h00};
    wire [2:0][7:0] q_latch = {strobe_port_latch, gp_port_latch, upper_port_latch};
    wire [2:0][7:0] q_en = {strb_en, 8'h00, {8{hi_drv}}};
    wire [2:0][7:0] q_val = {8'h00, 8'h00, cur_addr[15:8]};
    wire [2:0][7:0] q_out;
    wire [2:0][7:0] q_oe;

    // One driver per quasi port
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_quasi
            emb_quasi_drv u_drv
            (
                .core_clk(core_clk),
                .rstn_int(rstn_int),
                .latch(q_latch[gi]),
                .ovr_en(q_en[gi]),
                .ovr_val(q_val[gi]),
                .pin_out(q_out[gi]),
                .pin_oe(q_oe[gi])
            );
        end
    endgenerate

    // Pin fan-out
    assign upper_port_out = q_out[0];
    assign upper_port_oe = q_oe[0];
    assign gp_port_out = q_out[1];
    assign gp_port_oe = q_oe[1];
    assign strobe_port_out = q_out[2];
    assign strobe_port_oe = q_oe[2];

    // Checks wait two edges, until the pin registers follow live inputs
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!chk_live[1]);

    // Address strobe is two cycles high, then at least four low
    sequence s_ale_pulse;
        address_latch_strobe ##1 !address_latch_strobe [*4];
    endsequence

    sequence s_fetch_low;
        !program_fetch_strobe_n [*3] ##1 program_fetch_strobe_n;
    endsequence

    AST_ALE_SHAPE: assert property ($rose(address_latch_strobe) |=> s_ale_pulse)
        else $error("address strobe pulse shape wrong");
    AST_ALE_SKIP: assert property ($past(is_dstrb) |-> !address_latch_strobe)
        else $error("address strobe during data strobe slot");
    AST_ALE_RFI: assert property ($past(ale_sup_q && !is_daddr) |-> !address_latch_strobe)
        else $error("address strobe not suppressed");
    AST_PROGRAM_FETCH_STROBE_SHAPE: assert property ($fell(program_fetch_strobe_n) |-> s_fetch_low)
        else $error("fetch strobe not three cycles");
    AST_LOW_OD: assert property ($past(!bus_mode) |-> low_port_oe == ~$past(low_port_latch))
        else $error("open drain low port wrong");
    AST_LOW_ADDR: assert property ($past(is_fetch && ph == 3'h0) |->
        low_port_oe == 8'hff && low_port_out == $past(cur_addr[7:0]))
        else $error("low address not driven");
    AST_HI_ADDR: assert property ($past(is_fetch) |->
        upper_port_oe == 8'hff && upper_port_out == $past(cur_addr[15:8]))
        else $error("high address not driven");
    AST_HI_LATCH: assert property ($past(is_data && !cur_ptr) |->
        upper_port_oe == ~$past(upper_port_latch) && upper_port_out == 8'h00)
        else $error("upper latch not shown");
    AST_GP_QUASI: assert property (gp_port_out == 8'h00 && gp_port_oe == ~$past(gp_port_latch))
        else $error("general port not quasi");
    AST_RD_SLOT: assert property ($fell(strobe_port_out[RD_BIT] | ~strobe_port_oe[RD_BIT]) |->
        $past(is_dstrb && !cur_write))
        else $error("read strobe outside read slot");
    AST_STRAP: assert property ($past(strap_taken) && $past(lock_programmed)
        && lock_programmed |-> $stable(strap_eff))
        else $error("locked strap changed");
    AST_FETCH_EXT: assert property (fetch_req && fetch_addr >= INT_CODE_LIMIT |-> fetch_external)
        else $error("high fetch not external");
endmodule

// ---- tb/emb_mem_model.sv ----
// External code and data memory with address latch, seen from the bus
module emb_mem_model
(
    // Clock
    input wire logic core_clk,
    // Bus pins as resolved on the board
    input wire logic address_latch_strobe,
    input wire logic program_fetch_strobe_n,
    input wire logic [7:0] low_wire,
    input wire logic [7:0] upper_wire,
    input wire logic [7:0] strobe_wire,
    // Drive back onto the low port
    output logic [7:0] low_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] addr = 16'h0000;
    logic [7:0] last = 8'h00;
    logic [7:0] data_mem [0:65535];
    // Latch follows the bus on each edge while the strobe is high, then holds
    always @(posedge core_clk)
        if (address_latch_strobe === 1'b1)
            addr <= {upper_wire, low_wire};
    // Write data taken while the write strobe is low
    always @(posedge core_clk)
    begin
        last <= low_wire;
        if (strobe_wire[6] === 1'b0)
            data_mem[addr] <= low_wire;
    end
    // Released bus shows the inverse of its last level, not a stale copy
    always @*
        if (program_fetch_strobe_n === 1'b0)
            low_drv = addr[7:0] ^ addr[15:8] ^ 8'h3c;
        else if (strobe_wire[7] === 1'b0)
            low_drv = data_mem[addr];
        else
            low_drv = ~last;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the external memory bus ports
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import emb_pkg::*;
    logic core_clk = 0, resetn = 0, fetch_req = 0, data_req = 0, data_write = 0;
    logic external_access_strap = 0, lock_programmed = 0, ale_suppress = 0, data_pointer = 0;
    logic [7:0] low_port_latch = 8'hff, upper_port_latch = 8'hff, gp_port_latch = 8'hff;
    logic [7:0] strobe_port_latch = 8'hff, data_wdata = 8'h00, low_port_in, low_drv;
    logic [15:0] fetch_addr = 16'h0000, data_addr = 16'h0000;
    logic fetch_external, fetch_ack, data_ack, address_latch_strobe, program_fetch_strobe_n;
    logic [7:0] fetch_data, data_rdata, low_port_out, low_port_oe, upper_port_out;
    logic [7:0] upper_port_oe, gp_port_out, gp_port_oe, strobe_port_out, strobe_port_oe;
    logic [7:0] exp_q[$];
    logic [15:0] a;
    logic [7:0] d;
    int num_errors = 0, num_checks = 0, c;
    // Weak pullups on the quasi ports; open drain low port floats to the model
    wire [7:0] upper_wire = upper_port_oe & upper_port_out | ~upper_port_oe;
    wire [7:0] gp_wire = gp_port_oe & gp_port_out | ~gp_port_oe;
    wire [7:0] strobe_wire = strobe_port_oe & strobe_port_out | ~strobe_port_oe;
    assign low_port_in = low_port_oe & low_port_out | ~low_port_oe & low_drv;
    emb_bus_ports i_emb_bus_ports
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .low_port_latch(low_port_latch),
        .upper_port_latch(upper_port_latch),
        .gp_port_latch(gp_port_latch),
        .strobe_port_latch(strobe_port_latch),
        .external_access_strap(external_access_strap),
        .lock_programmed(lock_programmed),
        .ale_suppress(ale_suppress),
        .fetch_req(fetch_req),
        .fetch_addr(fetch_addr),
        .fetch_external(fetch_external),
        .fetch_ack(fetch_ack),
        .fetch_data(fetch_data),
        .data_req(data_req),
        .data_write(data_write),
        .data_pointer(data_pointer),
        .data_addr(data_addr),
        .data_wdata(data_wdata),
        .data_ack(data_ack),
        .data_rdata(data_rdata),
        .low_port_in(low_port_in),
        .low_port_out(low_port_out),
        .low_port_oe(low_port_oe),
        .upper_port_out(upper_port_out),
        .upper_port_oe(upper_port_oe),
        .gp_port_out(gp_port_out),
        .gp_port_oe(gp_port_oe),
        .strobe_port_out(strobe_port_out),
        .strobe_port_oe(strobe_port_oe),
        .address_latch_strobe(address_latch_strobe),
        .program_fetch_strobe_n(program_fetch_strobe_n)
    );
    emb_mem_model i_emb_mem_model
    (
        .core_clk(core_clk),
        .address_latch_strobe(address_latch_strobe),
        .program_fetch_strobe_n(program_fetch_strobe_n),
        .low_wire(low_port_in),
        .upper_wire(upper_wire),
        .strobe_wire(strobe_wire),
        .low_drv(low_drv)
    );
    always #2.5 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Pin reset is held two machine cycles, as the board must
    task automatic do_reset;
        resetn = 0;
        repeat (RESET_HOLD_CLKS) @(negedge core_clk);
        chk(low_port_oe | upper_port_oe | gp_port_oe | strobe_port_oe, 8'h00);
        chk({7'h0, program_fetch_strobe_n}, 8'h01);
        resetn = 1;
        repeat (4) @(negedge core_clk);
    endtask
    // Bounded wait for an answer, release after it, then one idle cycle
    task automatic wait_ack(input bit f);
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while ((f ? fetch_ack : data_ack) !== 1'b1 && n < 40);
        chk({7'h0, n < 40}, 8'h01);
        @(negedge core_clk);
        fetch_req = 0;
        data_req = 0;
        @(negedge core_clk);
    endtask
    task automatic fetch(input logic [15:0] fa);
        fetch_addr = fa;
        fetch_req = 1;
        exp_q.push_back(fa[7:0] ^ fa[15:8] ^ 8'h3c);
        wait_ack(1);
    endtask
    task automatic move(input logic w, input logic p, input logic [15:0] ma, input logic [7:0] md);
        data_write = w;
        data_pointer = p;
        data_addr = ma;
        data_wdata = md;
        data_req = 1;
        wait_ack(0);
    endtask
    task automatic ale_count(output int n);
        logic prev;
        n = 0;
        prev = address_latch_strobe;
        repeat (60)
        begin
            @(negedge core_clk);
            n += (address_latch_strobe && !prev);
            prev = address_latch_strobe;
        end
    endtask
    // Each answer is matched against the oldest note
    always @(negedge core_clk)
        if (fetch_ack === 1'b1 || (data_ack === 1'b1 && data_write === 1'b0))
            chk(data_ack ? data_rdata : fetch_data, exp_q.pop_front());
    initial
    begin
        #20000;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        test_done();
    end
    initial
    begin
        void'($urandom(65163));
        do_reset();
        @(negedge core_clk);
        gp_port_latch = 8'($urandom);
        upper_port_latch = 8'($urandom);
        low_port_latch = 8'($urandom);
        repeat (2) @(negedge core_clk);
        chk(gp_wire, gp_port_latch);
        chk(upper_wire, upper_port_latch);
        chk(low_port_oe, ~low_port_latch);
        // Strap low sends every address out, both ends included
        fetch(16'h0000);
        fetch(16'hffff);
        fetch(16'($urandom));
        a = 16'($urandom);
        d = 8'($urandom);
        fork
            ale_count(c);
            move(1, 1, a, d);
        join
        chk(c[7:0], 8'h09);
        exp_q.push_back(d);
        move(0, 1, a, 8'h00);
        // Upper latch stands in for the high byte on indirect moves
        upper_port_latch = a[15:8];
        exp_q.push_back(d);
        move(0, 0, {~a[15:8], a[7:0]}, 8'h00);
        ale_suppress = 1;
        ale_count(c);
        chk(c[7:0], 8'h00);
        ale_suppress = 0;
        ale_count(c);
        chk(c[7:0], 8'h0a);
        external_access_strap = 1;
        fetch_addr = 16'h3fff;
        @(negedge core_clk);
        chk({7'h0, fetch_external}, 8'h00);
        fetch(16'h4000);
        // Locked part keeps the strap level seen at reset
        lock_programmed = 1;
        do_reset();
        external_access_strap = 0;
        fetch_addr = 16'h0100;
        @(negedge core_clk);
        chk({7'h0, fetch_external}, 8'h00);
        lock_programmed = 0;
        @(negedge core_clk);
        chk({7'h0, fetch_external}, 8'h01);
        test_done();
    end
endmodule
